/* File: hw/dtfr_task_file.v */
// task file register bank facing the host i/o port cycles
`timescale 1ns/1ps
`default_nettype none
`include "dtfr_defines.vh"

module dtfr_task_file
(
  input wire sys_clk,
  input wire sys_rst,
  // host i/o port side
  input wire [2:0] host_addr,
  input wire host_rd,
  input wire host_wr,
  input wire [15:0] host_wdata,
  output reg [15:0] host_rdata,
  output wire host_wr_ready,
  output reg host_irq,
  // software reset from the control register group
  input wire soft_rst,
  // command hand-off to the execution engine
  output reg cmd_start,
  output reg [7:0] cmd_code,
  input wire cmd_done,
  input wire cmd_failed,
  input wire [7:0] fault_bits,
  input wire diag_done,
  input wire [7:0] diag_code,
  input wire sector_step,
  input wire ecc_byte_mode,
  // drive condition inputs
  input wire device_ready_flag,
  input wire write_fault_flag,
  input wire seek_done_flag,
  input wire transfer_request_flag,
  // parameter views for the engine
  output wire [8:0] sectors_to_move,
  output wire [7:0] sectors_per_track,
  output wire [27:0] lba_address,
  output wire lba_mode,
  output wire unit_select,
  output wire [3:0] head_select,
  output wire [3:0] max_heads,
  output wire [7:0] feature_code,
  // sector buffer read stream (drive to host)
  input wire [15:0] sbuf_rd_data,
  input wire sbuf_rd_valid,
  output wire sbuf_rd_ready,
  // sector buffer write stream (host to drive)
  output wire [15:0] sbuf_wr_data,
  output wire sbuf_wr_valid,
  input wire sbuf_wr_ready
);

  ////////////////////////////////////////////////////////////////////////////
  // register state

  reg [7:0] feature_select_q; // written only, steers set features
  reg [7:0] transfer_length_q; // sector count
  reg [7:0] start_sector_q; // sector number, lba bits 0-7
  reg [7:0] track_low_byte_q; // lba bits 8-15
  reg [7:0] track_high_byte_q; // lba bits 16-23
  reg [7:0] unit_and_head_select_q; // lba bits 24-27 in low nibble
  reg [7:0] fault_cause_q; // operational fault bits
  reg [7:0] diag_result_q; // completion code in diagnostic mode
  reg busy_q; // command in progress
  reg err_q; // previous command failed
  reg diag_mode_q; // high in diagnostic mode
  reg irq_q; // pending host interrupt request

  ////////////////////////////////////////////////////////////////////////////
  // two-entry buffer for host data headed to the sector buffer

  reg [15:0] fifo_mem_q [0:1]; // storage, indexed by pointer
  reg fifo_wp_q; // write pointer
  reg fifo_rp_q; // read pointer
  reg [1:0] fifo_cnt_q; // entries held

  wire fifo_full = fifo_cnt_q[1]; // both entries taken
  wire fifo_empty = (fifo_cnt_q == 2'b00);

  ////////////////////////////////////////////////////////////////////////////
  // decode of host cycles

  wire rd_data = host_rd && (host_addr == `DTFR_OFS_DATA);
  wire wr_data = host_wr && (host_addr == `DTFR_OFS_DATA);
  wire wr_cmd = host_wr && (host_addr == `DTFR_OFS_STAT_CMD);
  wire rd_stat = host_rd && (host_addr == `DTFR_OFS_STAT_CMD);
  // parameter writes are ignored while busy so a running command keeps them
  wire wr_param = host_wr && !busy_q;

  // host may push only when a slot is free; stalls propagate to the host
  assign host_wr_ready = !fifo_full;
  wire fifo_push = wr_data && !fifo_full;
  wire fifo_pop = sbuf_wr_valid && sbuf_wr_ready;

  // ecc bytes of long commands travel in the low lane only
  wire [15:0] wr_word = ecc_byte_mode ? {8'h00, host_wdata[7:0]} : host_wdata;

  assign sbuf_wr_valid = !fifo_empty;
  assign sbuf_wr_data = fifo_mem_q[fifo_rp_q];
  // a data read pops one word from the drive stream, never while busy;
  // an empty stream is never popped, the host then sees a stale word
  assign sbuf_rd_ready = rd_data && !busy_q && sbuf_rd_valid;

  ////////////////////////////////////////////////////////////////////////////
  // command classification

  // known operation codes; anything else is refused
  function cmd_known;
    input [7:0] op;
    begin
      case (op)
        8'h20, 8'h21, 8'h22, 8'h23, 8'h40, 8'h41, 8'hE4, 8'hC4, 8'hC8,
        8'hC9, 8'h30, 8'h31, 8'h32, 8'h33, 8'h3C, 8'hE8, 8'hC5, 8'hCA,
        8'hCB, 8'hEF, 8'hC6, 8'hF8, 8'hF9, 8'h94, 8'hE0, 8'h95, 8'hE1,
        8'h96, 8'hE2, 8'h97, 8'hE3, 8'h98, 8'hE5, 8'h99, 8'hE6, 8'hEC,
        8'h91, 8'h50, 8'h90, 8'hB0:
          cmd_known = 1'b1;
        default:
          cmd_known = (op[7:4] == 4'h1) || (op[7:4] == 4'h7); // recalibrate, seek
      endcase
    end
  endfunction

  // commands that take a block address
  function cmd_lba_ok;
    input [7:0] op;
    begin
      case (op)
        8'h20, 8'h21, 8'h22, 8'h23, 8'h40, 8'h41, 8'hC4, 8'hC8, 8'hC9,
        8'h30, 8'h31, 8'h32, 8'h33, 8'h3C, 8'hC5, 8'hCA, 8'hCB, 8'h50:
          cmd_lba_ok = 1'b1;
        default:
          cmd_lba_ok = (op[7:4] == 4'h7);
      endcase
    end
  endfunction

  wire [7:0] op_in = host_wdata[7:0];
  wire lba_bad = unit_and_head_select_q[`DTFR_UH_LBA] && !cmd_lba_ok(op_in);
  // refusal causes checked at the moment the command lands
  wire abort_now = !cmd_known(op_in) || !device_ready_flag
                   || write_fault_flag || lba_bad;
  // a command written while busy is dropped
  wire take_cmd = wr_cmd && !busy_q;

  ////////////////////////////////////////////////////////////////////////////
  // status assembly

  wire [7:0] drive_state;
  assign drive_state[`DTFR_ST_BUSY] = busy_q;
  assign drive_state[`DTFR_ST_READY] = device_ready_flag;
  assign drive_state[`DTFR_ST_FAULT] = write_fault_flag;
  assign drive_state[`DTFR_ST_SEEK] = seek_done_flag;
  assign drive_state[`DTFR_ST_XFER] = transfer_request_flag;
  assign drive_state[2:1] = 2'b00;
  assign drive_state[`DTFR_ST_ERR] = err_q;

  // fault cause view depends on mode; unused bits forced low outside diagnostic mode
  wire [7:0] fault_cause = diag_mode_q ? diag_result_q
                           : (fault_cause_q & `DTFR_FC_USED_MASK);

  ////////////////////////////////////////////////////////////////////////////
  // parameter views

  assign sectors_to_move = (transfer_length_q == `DTFR_RST_BYTE)
                           ? `DTFR_FULL_COUNT : {1'b0, transfer_length_q};
  assign sectors_per_track = transfer_length_q;
  assign lba_address = {unit_and_head_select_q[3:0], track_high_byte_q,
                        track_low_byte_q, start_sector_q};
  assign lba_mode = unit_and_head_select_q[`DTFR_UH_LBA];
  assign unit_select = unit_and_head_select_q[`DTFR_UH_UNIT];
  assign head_select = unit_and_head_select_q[3:0];
  assign max_heads = unit_and_head_select_q[3:0];
  assign feature_code = feature_select_q;

  ////////////////////////////////////////////////////////////////////////////
  // host write path into the parameter registers

  always @(posedge sys_clk)
  begin
    if (sys_rst || soft_rst)
    begin
      feature_select_q <= `DTFR_RST_BYTE;
      transfer_length_q <= `DTFR_RST_COUNT;
      start_sector_q <= `DTFR_RST_SECTOR;
      track_low_byte_q <= `DTFR_RST_BYTE;
      track_high_byte_q <= `DTFR_RST_BYTE;
      unit_and_head_select_q <= `DTFR_RST_UNIT;
    end
    else
    begin
      // host writes land only when idle
      if (wr_param)
      begin
        case (host_addr)
          `DTFR_OFS_ERR_FEAT: feature_select_q <= host_wdata[7:0];
          `DTFR_OFS_COUNT: transfer_length_q <= host_wdata[7:0];
          `DTFR_OFS_SECTOR: start_sector_q <= host_wdata[7:0];
          `DTFR_OFS_TRK_LO: track_low_byte_q <= host_wdata[7:0];
          `DTFR_OFS_TRK_HI: track_high_byte_q <= host_wdata[7:0];
          // fixed-one bits are forced whatever the host writes
          `DTFR_OFS_UNIT: unit_and_head_select_q <= host_wdata[7:0] | `DTFR_UH_FIXED;
          default:
          begin
          end
        endcase
      end
      // engine steps a sector: count down, sector number up; the last
      // values stand if the engine stops on an error
      else if (sector_step && busy_q)
      begin
        transfer_length_q <= transfer_length_q - `DTFR_ONE_BYTE;
        start_sector_q <= start_sector_q + `DTFR_ONE_BYTE;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // command acceptance, busy, error, mode and interrupt

  always @(posedge sys_clk)
  begin
    if (sys_rst || soft_rst)
    begin
      busy_q <= 1'b0;
      err_q <= 1'b0;
      diag_mode_q <= 1'b1;
      irq_q <= 1'b0;
      fault_cause_q <= `DTFR_RST_BYTE;
      diag_result_q <= `DTFR_ONE_BYTE;
      cmd_start <= 1'b0;
      cmd_code <= `DTFR_RST_BYTE;
    end
    else
    begin
      cmd_start <= 1'b0;
      if (take_cmd)
      begin
        cmd_code <= op_in;
        irq_q <= 1'b0;
        if (abort_now)
        begin
          // refused at once: no engine start, error reported now
          busy_q <= 1'b0;
          err_q <= 1'b1;
          diag_mode_q <= 1'b0;
          fault_cause_q <= `DTFR_FC_ABORT_CODE;
          irq_q <= 1'b1;
        end
        else
        begin
          busy_q <= 1'b1;
          err_q <= 1'b0;
          cmd_start <= 1'b1;
          diag_mode_q <= (op_in == `DTFR_OP_DIAG);
          fault_cause_q <= `DTFR_RST_BYTE;
        end
      end
      else
      begin
        // engine finished: busy drops, interrupt raised
        if (busy_q && (cmd_done || diag_done))
        begin
          busy_q <= 1'b0;
          irq_q <= 1'b1;
          if (diag_mode_q)
          begin
            diag_result_q <= diag_code;
          end
          else
          begin
            err_q <= cmd_failed;
            // fault cause bits: crc, ecc, id, abort, home, address mark
            fault_cause_q <= fault_bits & `DTFR_FC_USED_MASK;
          end
        end
        // a status read clears the request, but a completion in the
        // same cycle wins over the clear
        else if (rd_stat)
        begin
          irq_q <= 1'b0;
        end
      end
    end
  end

  always @*
  begin
    host_irq = irq_q;
  end

  ////////////////////////////////////////////////////////////////////////////
  // host read data, registered one cycle after the strobe

  always @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      host_rdata <= `DTFR_ZERO_WORD;
    end
    else if (host_rd)
    begin
      if (busy_q)
      begin
        // every offset answers with status while busy
        host_rdata <= {8'h00, drive_state};
      end
      else
      begin
        case (host_addr)
          `DTFR_OFS_DATA:
            host_rdata <= ecc_byte_mode ? {8'h00, sbuf_rd_data[7:0]}
                          : sbuf_rd_data;
          `DTFR_OFS_ERR_FEAT: host_rdata <= {8'h00, fault_cause};
          `DTFR_OFS_COUNT: host_rdata <= {8'h00, transfer_length_q};
          `DTFR_OFS_SECTOR: host_rdata <= {8'h00, start_sector_q};
          `DTFR_OFS_TRK_LO: host_rdata <= {8'h00, track_low_byte_q};
          `DTFR_OFS_TRK_HI: host_rdata <= {8'h00, track_high_byte_q};
          `DTFR_OFS_UNIT: host_rdata <= {8'h00, unit_and_head_select_q};
          default: host_rdata <= {8'h00, drive_state};
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // buffer pointers and storage

  always @(posedge sys_clk)
  begin
    if (sys_rst || soft_rst)
    begin
      fifo_wp_q <= 1'b0;
      fifo_rp_q <= 1'b0;
      fifo_cnt_q <= 2'b00;
    end
    else
    begin
      if (fifo_push)
      begin
        fifo_wp_q <= ~fifo_wp_q;
      end
      if (fifo_pop)
      begin
        fifo_rp_q <= ~fifo_rp_q;
      end
      case ({fifo_push, fifo_pop})
        2'b10: fifo_cnt_q <= fifo_cnt_q + 2'b01;
        2'b01: fifo_cnt_q <= fifo_cnt_q - 2'b01;
        default: fifo_cnt_q <= fifo_cnt_q;
      endcase
    end
  end

  // storage needs no reset; only written entries are ever presented
  always @(posedge sys_clk)
  begin
    if (fifo_push)
    begin
      fifo_mem_q[fifo_wp_q] <= wr_word;
    end
  end

endmodule
`default_nettype wire

/* File: hw/dtfr_defines.vh */
// constants for the disk task file register bank
`ifndef DTFR_DEFINES_VH
`define DTFR_DEFINES_VH

// port offsets, reads and writes share an offset but may differ in target
`define DTFR_OFS_DATA 3'h0
`define DTFR_OFS_ERR_FEAT 3'h1
`define DTFR_OFS_COUNT 3'h2
`define DTFR_OFS_SECTOR 3'h3
`define DTFR_OFS_TRK_LO 3'h4
`define DTFR_OFS_TRK_HI 3'h5
`define DTFR_OFS_UNIT 3'h6
`define DTFR_OFS_STAT_CMD 3'h7

// status bit positions
`define DTFR_ST_BUSY 7
`define DTFR_ST_READY 6
`define DTFR_ST_FAULT 5
`define DTFR_ST_SEEK 4
`define DTFR_ST_XFER 3
`define DTFR_ST_ERR 0

// fault cause bit positions
`define DTFR_FC_CRC 7
`define DTFR_FC_ECC 6
`define DTFR_FC_IDMISS 4
`define DTFR_FC_ABORT 2
`define DTFR_FC_HOME 1
`define DTFR_FC_AMARK 0
`define DTFR_FC_USED_MASK 8'hD7
`define DTFR_FC_ABORT_CODE 8'h04

// unit and head select fields
`define DTFR_UH_LBA 6
`define DTFR_UH_UNIT 4
`define DTFR_UH_FIXED 8'hA0
`define DTFR_UH_FIXED_MASK 8'hA0

// reset values
`define DTFR_RST_BYTE 8'h00
`define DTFR_RST_COUNT 8'h01
`define DTFR_RST_SECTOR 8'h01
`define DTFR_RST_UNIT 8'hA0
`define DTFR_ZERO_WORD 16'h0000
`define DTFR_ONE_BYTE 8'h01
`define DTFR_FULL_COUNT 9'h100

// operation codes with special handling
`define DTFR_OP_DIAG 8'h90
`define DTFR_OP_PARAMS 8'h91
`define DTFR_OP_FORMAT 8'h50

`endif

/* File: sim/dtfr_engine_model.sv */
// far side model: command engine and sector buffer streams
`timescale 1ns/1ps
`default_nettype none
module dtfr_engine (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic cmd_start,
  input wire logic [7:0] cmd_code,
  input wire logic [3:0] lat,
  input wire logic stall,
  input wire logic sbuf_rd_ready,
  input wire logic [15:0] sbuf_wr_data,
  input wire logic sbuf_wr_valid,
  output logic cmd_done,
  output logic diag_done,
  output logic sector_step,
  output logic [15:0] sbuf_rd_data,
  output logic sbuf_wr_ready
);
  logic [3:0] cnt_q; // cycles left in the running command
  logic [15:0] word_q; // next word offered to the host
  logic [15:0] got [$]; // words taken from the write stream
  // a stall holds the write stream off, so the buffer must keep words
  assign sbuf_wr_ready = !stall;
  assign sbuf_rd_data = word_q;
  // one step per cycle, then a finish pulse that never meets a step
  always @(posedge sys_clk)
  begin
    cmd_done <= 1'b0;
    diag_done <= 1'b0;
    sector_step <= 1'b0;
    if (sys_rst)
    begin
      cnt_q <= 4'h0;
      word_q <= 16'hA5C3;
    end
    else
    begin
      if (cmd_start)
        cnt_q <= lat;
      else if (cnt_q != 4'h0)
        cnt_q <= cnt_q - 4'h1;
      if (cnt_q > 4'h1)
        sector_step <= 1'b1;
      if (cnt_q == 4'h1)
      begin
        diag_done <= (cmd_code == 8'h90);
        cmd_done <= (cmd_code != 8'h90);
      end
      if (sbuf_rd_ready)
        word_q <= word_q + 16'h1357;
      if (sbuf_wr_valid && sbuf_wr_ready)
        got.push_back(sbuf_wr_data);
    end
  end
endmodule
`default_nettype wire

/* File: sim/dtfr_task_file_asserts.sv */
// assertion checker bound to the task file bank ports
`timescale 1ns/1ps
`default_nettype none
module dtfr_chk (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic soft_rst,
  input wire logic [2:0] host_addr,
  input wire logic host_rd,
  input wire logic host_wr,
  input wire logic [15:0] host_rdata,
  input wire logic host_irq,
  input wire logic cmd_start,
  input wire logic cmd_done,
  input wire logic diag_done,
  input wire logic sector_step,
  input wire logic ecc_byte_mode,
  input wire logic device_ready_flag,
  input wire logic [8:0] sectors_to_move,
  input wire logic [15:0] sbuf_rd_data,
  input wire logic sbuf_rd_ready,
  input wire logic [15:0] sbuf_wr_data,
  input wire logic sbuf_wr_valid,
  input wire logic sbuf_wr_ready
);
  ////////////////////////////////////////////////////////////
  logic eb_q; // engine owns a command; always inside busy
  logic [8:0] nxt; // count view after one sector
  // start to finish of a handed-off command
  always @(posedge sys_clk)
  begin
    if (sys_rst || soft_rst)
      eb_q <= 1'b0;
    else if (cmd_start)
      eb_q <= 1'b1;
    else if (cmd_done || diag_done)
      eb_q <= 1'b0;
  end
  // one left wraps to the zero code, read as 256
  assign nxt = (sectors_to_move == 9'h001) ? 9'h100 : sectors_to_move - 9'h001;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (sys_rst || soft_rst);
  sequence s_cmd_wr;
    host_wr && host_addr == 3'h7 && !eb_q;
  endsequence
  sequence s_stat_rd;
    host_rd && host_addr == 3'h7 && !host_wr && !cmd_done && !diag_done;
  endsequence
  ////////////////////////////////////////////////////////////
  a_abort_unready: assert property (s_cmd_wr ##0 !device_ready_flag |=> !cmd_start)
    else $error("command started while not ready");
  a_stat_clear: assert property (s_stat_rd |=> !host_irq)
    else $error("status read left interrupt pending");
  a_start_quiet: assert property (cmd_start |-> !host_irq)
    else $error("interrupt pending at command start");
  a_done_irq: assert property (cmd_done && eb_q |=> host_irq)
    else $error("no interrupt after command end");
  a_busy_reads: assert property (host_rd && host_addr != 3'h7 && eb_q && !cmd_done
    && !diag_done |=> host_rdata[15:7] == 9'h001)
    else $error("busy read did not return status");
  a_pop_gate: assert property (sbuf_rd_ready |-> host_rd && host_addr == 3'h0 && !eb_q)
    else $error("buffer popped outside a data read");
  a_pop_word: assert property (sbuf_rd_ready |=> host_rdata == ($past(sbuf_rd_data)
    & ($past(ecc_byte_mode) ? 16'h00FF : 16'hFFFF)))
    else $error("data port word wrong");
  a_wr_hold: assert property (sbuf_wr_valid && !sbuf_wr_ready |=>
    sbuf_wr_valid && $stable(sbuf_wr_data))
    else $error("stalled write word not held");
  a_count_step: assert property (sector_step && eb_q && !host_wr && !cmd_done |=>
    sectors_to_move == $past(nxt))
    else $error("count did not step down");
endmodule
bind dtfr_task_file dtfr_chk u_chk (.sys_clk, .sys_rst, .soft_rst, .host_addr, .host_rd,
  .host_wr, .host_rdata, .host_irq, .cmd_start, .cmd_done, .diag_done, .sector_step,
  .ecc_byte_mode, .device_ready_flag, .sectors_to_move, .sbuf_rd_data, .sbuf_rd_ready,
  .sbuf_wr_data, .sbuf_wr_valid, .sbuf_wr_ready);
`default_nettype wire

/* File: sim/test_disk_task_file_registers.sv */
// self-checking bench for the task file bank
`timescale 1ns/1ps
`default_nettype none
module test_disk_task_file_registers;
  logic sys_clk, sys_rst, soft_rst, host_rd, host_wr, ecc_byte_mode, rdy, flt, seek, xfer;
  logic fail, stall, cmd_done, diag_done, sector_step, host_wr_ready, host_irq, cmd_start;
  logic sbuf_rd_ready, sbuf_wr_valid, sbuf_wr_ready, lba_mode, unit_select;
  logic [2:0] host_addr;
  logic [3:0] lat, head_select, max_heads;
  logic [7:0] fbits, dcode, cmd_code, sectors_per_track, feature_code;
  logic [8:0] sectors_to_move;
  logic [15:0] host_wdata, host_rdata, sbuf_rd_data, sbuf_wr_data, v, e;
  logic [27:0] lba_address;
  logic [7:0] m [0:7]; // expected register contents
  logic [15:0] wq [$]; // expected write stream
  int seed = 27491;
  int miscompares = 0;
  int cmp_count = 0;
  dtfr_task_file u_dut (.sys_clk, .sys_rst, .host_addr, .host_rd, .host_wr, .host_wdata,
    .host_rdata, .host_wr_ready, .host_irq, .soft_rst, .cmd_start, .cmd_code, .cmd_done,
    .cmd_failed(fail), .fault_bits(fbits), .diag_done, .diag_code(dcode), .sector_step,
    .ecc_byte_mode, .device_ready_flag(rdy), .write_fault_flag(flt), .seek_done_flag(seek),
    .transfer_request_flag(xfer), .sectors_to_move, .sectors_per_track, .lba_address,
    .lba_mode, .unit_select, .head_select, .max_heads, .feature_code, .sbuf_rd_data,
    .sbuf_rd_valid(1'b1), .sbuf_rd_ready, .sbuf_wr_data, .sbuf_wr_valid, .sbuf_wr_ready);
  dtfr_engine u_eng (.sys_clk, .sys_rst, .cmd_start, .cmd_code, .lat, .stall, .sbuf_rd_ready,
    .sbuf_wr_data, .sbuf_wr_valid, .cmd_done, .diag_done, .sector_step, .sbuf_rd_data,
    .sbuf_wr_ready);
  ////////////////////////////////////////////////////////////
  initial
  begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  task automatic chk(input logic [15:0] g, input logic [15:0] x);
    cmp_count++;
    if (g !== x)
    begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask
  // one strobe cycle; inputs move on the falling edge only
  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(negedge sys_clk);
    host_addr = a;
    host_wdata = d;
    host_wr = 1'b1;
    @(negedge sys_clk);
    host_wr = 1'b0;
  endtask
  task automatic rc(input logic [2:0] a, input logic [15:0] x);
    @(negedge sys_clk);
    host_addr = a;
    host_rd = 1'b1;
    @(negedge sys_clk);
    host_rd = 1'b0;
    chk(host_rdata, x);
  endtask
  // bounded wait for the completion interrupt
  task automatic wt;
    for (int n = 0; n < 60 && host_irq !== 1'b1; n++)
      @(negedge sys_clk);
  endtask
  function automatic logic [15:0] st(input logic b, input logic er);
    return {8'h00, b, rdy, flt, seek, xfer, 2'b00, er};
  endfunction
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // watchdog well beyond the few hundred cycles the run needs
  initial
  begin
    #60000;
    miscompares++;
    conclude;
  end
  ////////////////////////////////////////////////////////////
  initial
  begin
    {sys_rst, soft_rst, host_rd, host_wr, ecc_byte_mode, fail, stall} = 7'h40;
    {rdy, flt, seek, xfer, host_addr, host_wdata, lat, fbits, dcode} = 0;
    m = '{8'h00, 8'h00, 8'h01, 8'h01, 8'h00, 8'h00, 8'hA0, 8'h00};
    repeat (4) @(negedge sys_clk);
    sys_rst = 1'b0;
    rc(3'h1, 16'h0001);
    for (int i = 2; i < 7; i++)
      rc(3'(i), {8'h00, m[i]});
    // random drive conditions seen through the status port
    for (int i = 0; i < 8; i++)
    begin
      v = $random(seed);
      {rdy, flt, seek, xfer} = v[3:0];
      rc(3'h7, st(1'b0, 1'b0));
    end
    {rdy, flt} = 2'b10;
    for (int i = 1; i < 7; i++)
    begin
      v = $random(seed);
      m[i] = (i == 6) ? (v[7:0] | 8'hA0) : v[7:0];
      wr(3'(i), v);
    end
    chk(feature_code, m[1]);
    chk(lba_address[15:0], {m[4], m[3]});
    chk(lba_address[27:16], {m[6][3:0], m[5]});
    chk({lba_mode, unit_select, head_select, max_heads}, {m[6][6], m[6][4:0], m[6][3:0]});
    for (int i = 2; i < 7; i++)
      rc(3'(i), {8'h00, m[i]});
    wr(3'h2, 16'h0000);
    chk(sectors_to_move, 9'h100);
    chk(sectors_per_track, 8'h00);
    // three sectors of five, busy reads answered with status
    wr(3'h2, 16'h0005);
    wr(3'h3, 16'h0010);
    wr(3'h6, 16'h00A0);
    lat = 4'h4;
    wr(3'h7, 16'h0020);
    rc(3'h2, st(1'b1, 1'b0));
    wt;
    chk(host_irq, 1'b1);
    rc(3'h2, 16'h0002);
    rc(3'h3, 16'h0013);
    rc(3'h1, 16'h0000);
    rc(3'h7, st(1'b0, 1'b0));
    chk(host_irq, 1'b0);
    // failing command keeps the remainder and reports the cause
    fail = 1'b1;
    v = $random(seed);
    fbits = v[7:0];
    wr(3'h2, 16'h0004);
    lat = 4'h3;
    wr(3'h7, 16'h0030);
    wt;
    rc(3'h2, 16'h0002);
    rc(3'h1, {8'h00, fbits & 8'hD7});
    rc(3'h7, st(1'b0, 1'b1));
    fail = 1'b0;
    // bad code, not ready, write fault, block mode on a head-only command
    for (int k = 0; k < 4; k++)
    begin
      rdy = (k != 1);
      flt = (k == 2);
      wr(3'h6, (k == 3) ? 16'h00E0 : 16'h00A0);
      wr(3'h7, (k == 0) ? 16'h00FF : (k == 3) ? 16'h0010 : 16'h0020);
      wt;
      rc(3'h1, 16'h0004);
      rc(3'h7, st(1'b0, 1'b1));
    end
    {rdy, flt} = 2'b10;
    // a refused code leaves an interrupt pending; the next command clears it
    wr(3'h7, 16'h00FF);
    wr(3'h6, 16'h00A0);
    v = $random(seed);
    dcode = v[7:0];
    lat = 4'h1;
    wr(3'h7, 16'h0090);
    chk(host_irq, 1'b0);
    wt;
    rc(3'h1, {8'h00, dcode});
    chk(cmd_code, 16'h0090);
    // write stream: fill against a stall, then drain with random stalls
    for (int i = 0; i < 14; i++)
    begin
      @(negedge sys_clk);
      v = $random(seed);
      stall = (i < 5) || v[15];
      ecc_byte_mode = v[14];
      host_addr = 3'h0;
      host_wdata = v;
      host_wr = host_wr_ready;
      if (host_wr_ready === 1'b1)
        wq.push_back(ecc_byte_mode ? (v & 16'h00FF) : v);
      if (i == 4)
        chk(wq.size(), 2);
    end
    @(negedge sys_clk);
    {host_wr, stall} = 2'b00;
    repeat (6) @(negedge sys_clk);
    chk(u_eng.got.size(), wq.size());
    foreach (wq[i])
      chk(u_eng.got[i], wq[i]);
    // read stream, mixing whole words and single bytes
    e = 16'hA5C3;
    for (int i = 0; i < 6; i++)
    begin
      v = $random(seed);
      ecc_byte_mode = v[0];
      rc(3'h0, v[0] ? (e & 16'h00FF) : e);
      e = e + 16'h1357;
    end
    wr(3'h2, 16'h0033);
    soft_rst = 1'b1;
    @(negedge sys_clk);
    soft_rst = 1'b0;
    rc(3'h2, 16'h0001);
    rc(3'h1, 16'h0001);
    conclude;
  end
endmodule
`default_nettype wire
